// [src/pcr_pkg.sv]
package pcr_pkg;
    // Register offsets
    localparam logic [6:0] PCR_ADDR_MAIN_CTRL   = 7'h00;
    localparam logic [6:0] PCR_ADDR_CORE_STAT   = 7'h01;
    localparam logic [6:0] PCR_ADDR_RATE_SEL    = 7'h04;
    localparam logic [6:0] PCR_ADDR_COARSE_HI   = 7'h06;
    localparam logic [6:0] PCR_ADDR_COARSE_LO   = 7'h07;
    localparam logic [6:0] PCR_ADDR_PART_ID     = 7'h0f;
    localparam logic [6:0] PCR_ADDR_T1_OFFSET   = 7'h11;
    localparam logic [6:0] PCR_ADDR_DISABLE_A   = 7'h13;
    localparam logic [6:0] PCR_ADDR_DISABLE_B   = 7'h14;
    localparam logic [6:0] PCR_ADDR_RECOVERY    = 7'h19;
    localparam logic [6:0] PCR_ADDR_FINE_OFFSET = 7'h1a;
    localparam logic [6:0] PCR_ADDR_PRI_STAT    = 7'h20;
    localparam logic [6:0] PCR_ADDR_SEC_STAT    = 7'h28;
    localparam logic [6:0] PCR_ADDR_CAL_B3      = 7'h40;
    localparam logic [6:0] PCR_ADDR_CAL_B2      = 7'h41;
    localparam logic [6:0] PCR_ADDR_CAL_B1      = 7'h42;
    localparam logic [6:0] PCR_ADDR_CAL_B0      = 7'h43;

    // Write masks: writable bits per register
    localparam logic [7:0] PCR_MASK_MAIN_CTRL   = 8'h9d;
    localparam logic [7:0] PCR_MASK_RATE_SEL    = 8'hc0;
    localparam logic [7:0] PCR_MASK_COARSE_HI   = 8'h0f;
    localparam logic [7:0] PCR_MASK_T1_OFFSET   = 8'h38;
    localparam logic [7:0] PCR_MASK_DISABLE_A   = 8'h3e;
    localparam logic [7:0] PCR_MASK_DISABLE_B   = 8'h1f;
    localparam logic [7:0] PCR_MASK_RECOVERY    = 8'h06;
    localparam logic [7:0] PCR_MASK_FULL        = 8'hff;

    // Reset values
    localparam logic [7:0] PCR_RST_MAIN_CTRL    = 8'h11;
    localparam logic [7:0] PCR_RST_ZERO         = 8'h00;

    // Field positions in main control
    localparam int PCR_BIT_SRC       = 7;
    localparam int PCR_BIT_OP_HI     = 4;
    localparam int PCR_BIT_OP_LO     = 3;
    localparam int PCR_BIT_FILTER    = 2;
    localparam int PCR_BIT_REALIGN   = 0;
    // Core status fields
    localparam int PCR_BIT_LOCK      = 5;
    localparam int PCR_BIT_HOLD      = 4;
    localparam int PCR_BIT_CORE_RANGE_EDGE_FLAG      = 2;
    // Acquisition status fields
    localparam int PCR_BIT_RATE_HI   = 4;
    localparam int PCR_BIT_RATE_LO   = 3;
    localparam int PCR_BIT_ACQ_HOLD  = 1;
    localparam int PCR_BIT_ACQ_RANGE = 0;
    // Coarse offset high fields
    localparam int PCR_BIT_OFF_EN    = 3;
    // Recovery fields
    localparam int PCR_BIT_MHR       = 2;
    localparam int PCR_BIT_AUTO_HOLD_RECOVERY_DISABLE      = 1;

    // Filter characteristics
    localparam int PCR_FILT0_CORNER_MHZ  = 1100;
    localparam int PCR_FILT0_SLOPE_NS    = 41;
    localparam int PCR_FILT0_WINDOW_US   = 1326;
    localparam int PCR_FILT1_CORNER_MHZ  = 100;
    localparam int PCR_FILT1_SLOPE_NS    = 885;
    localparam int PCR_FILT1_WINDOW_US   = 1000000;

    // Operating modes
    typedef enum logic [1:0] {
        PCR_OP_NORMAL   = 2'b00,
        PCR_OP_HOLDOVER = 2'b01,
        PCR_OP_FREERUN  = 2'b10,
        PCR_OP_RESERVED = 2'b11
    } pcr_op_type;

    // Effective control handed to the loop datapath
    typedef struct packed {
        pcr_op_type  op_mode;
        logic        filter_sel;
        logic        source_sel;
        logic        realign_start;
        logic        coarse_en;
        logic [10:0] coarse_value;
        logic [2:0]  t1_value;
        logic [7:0]  fine_value;
        logic [13:0] out_disable;
        logic        auto_hold_rec_dis;
        logic        manual_release;
        logic [31:0] osc_cal_value;
        logic [1:0]  rate_sel;
    } pcr_ctrl_type;

    // Status from the loop datapath
    typedef struct packed {
        logic       core_locked;
        logic       core_range_edge_flag;
        logic       primary_acq_hold_flag;
        logic       primary_range_flag;
        logic [1:0] primary_rate;
        logic       secondary_acq_hold_flag;
        logic       secondary_range_flag;
        logic [1:0] secondary_rate;
    } pcr_stat_type;
endpackage

// [src/pcr_bank.sv]
// Operation
// - Strap low selects register control, else pins
// - Register control ignores mode, filter, source, realign pins
// - Lock and holdover pins always driven
// - Registers accessible also under pin control
// - Mode codes: normal, holdover, free-run, reserved
// - Mode pins captured on frame pulse rise
// - Filter 0: 1.1 Hz, 41 ns per 1.326 ms
// - Filter 1: 0.1 Hz, 885 ns per second
// - Source 0 primary, 1 secondary acquisition loop
// - Source pin sampled on frame pulse rise
// - Realign input commands output phase realignment
// - Lock high when core locked to selected loop
// - Holdover on selected loop holdover or mode 01
// - Seven control bits incl. two recovery bits
// - Range and acquisition holdover status bits
// - Status pins stay enabled under register control
// - Coarse offset: enable plus eleven bits
// - Calibration word over four bytes, MSB first
// - Per-output disable bits in two registers
// - Acquisition status: rate, hold, range flags
// - Realign falling edge starts alignment
// - Range flag at tracking range edge
`timescale 1ns/1ps
module pcr_bank
    import pcr_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h5a  // Arbitrary identification value
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         pin_control_strap,
    input  wire logic         op_select_high,
    input  wire logic         op_select_low,
    input  wire logic         loop_filter_select,
    input  wire logic         source_choice,
    input  wire logic         phase_realign,
    input  wire logic         frame_pulse_8k_out,
    input  wire logic         cs_n,
    input  wire logic         rd_wr_n,
    input  wire logic         ds_n,
    input  wire logic [6:0]   addr,
    input  wire logic [7:0]   wdata,
    output logic      [7:0]   rdata,
    output logic              rdata_oe,
    input  wire pcr_stat_type stat_in,
    output pcr_ctrl_type      ctrl_out,
    output logic              lock_out,
    output logic              holdover_out
);

    typedef struct packed {
        logic [7:0]   main_ctrl;
        logic [7:0]   rate_sel;
        logic [7:0]   coarse_hi;
        logic [7:0]   coarse_lo;
        logic [7:0]   t1_off;
        logic [7:0]   dis_a;
        logic [7:0]   dis_b;
        logic [7:0]   recovery;
        logic [7:0]   fine;
        logic [31:0]  cal;
        pcr_op_type   pin_mode;
        logic         pin_source;
        logic         frame_q;
        logic         realign_q;
        logic         ds_q;
        logic [7:0]   rdata;
        logic         rdata_oe;
        pcr_ctrl_type ctrl;
        logic         lock;
        logic         hold;
    } pcr_state_type;

    pcr_state_type s_q;
    pcr_state_type s_d;

    logic       sw_mode;
    logic       wr_stb;
    logic       rd_act;
    logic       eff_realign;
    pcr_op_type req_mode;
    pcr_op_type eff_mode;
    logic       sel_hold;
    logic [7:0] rd_mux;

    // Control source selection
    assign sw_mode = ~pin_control_strap;
    assign wr_stb  = ~cs_n & ~ds_n & s_q.ds_q & ~rd_wr_n;
    assign rd_act  = ~cs_n & ~ds_n & rd_wr_n;

    // Effective control bits, pins ignored under register control
    always_comb begin
        if (sw_mode) begin
            req_mode    = pcr_op_type'({s_q.main_ctrl[PCR_BIT_OP_HI],
                                        s_q.main_ctrl[PCR_BIT_OP_LO]});
            eff_realign = s_q.main_ctrl[PCR_BIT_REALIGN];
        end else begin
            req_mode    = s_q.pin_mode;
            eff_realign = phase_realign;
        end
        // Reserved code holds the mode in force
        eff_mode = (req_mode == PCR_OP_RESERVED) ? s_q.ctrl.op_mode : req_mode;
        sel_hold = s_q.ctrl.source_sel ? stat_in.secondary_acq_hold_flag
                                       : stat_in.primary_acq_hold_flag;
    end

    // Read multiplexer over the listed registers
    always_comb begin
        case (addr)
            PCR_ADDR_MAIN_CTRL:   rd_mux = s_q.main_ctrl;
            PCR_ADDR_CORE_STAT: begin
                rd_mux = PCR_RST_ZERO;
                rd_mux[PCR_BIT_LOCK] = s_q.lock;
                rd_mux[PCR_BIT_HOLD] = s_q.hold;
                rd_mux[PCR_BIT_CORE_RANGE_EDGE_FLAG] = stat_in.core_range_edge_flag;
            end
            PCR_ADDR_RATE_SEL:    rd_mux = s_q.rate_sel;
            PCR_ADDR_COARSE_HI:   rd_mux = s_q.coarse_hi;
            PCR_ADDR_COARSE_LO:   rd_mux = s_q.coarse_lo;
            PCR_ADDR_PART_ID:     rd_mux = PART_ID;
            PCR_ADDR_T1_OFFSET:   rd_mux = s_q.t1_off;
            PCR_ADDR_DISABLE_A:   rd_mux = s_q.dis_a;
            PCR_ADDR_DISABLE_B:   rd_mux = s_q.dis_b;
            PCR_ADDR_RECOVERY:    rd_mux = s_q.recovery;
            PCR_ADDR_FINE_OFFSET: rd_mux = s_q.fine;
            PCR_ADDR_PRI_STAT: begin
                rd_mux = PCR_RST_ZERO;
                rd_mux[PCR_BIT_RATE_HI:PCR_BIT_RATE_LO] = stat_in.primary_rate;
                rd_mux[PCR_BIT_ACQ_HOLD]  = stat_in.primary_acq_hold_flag;
                rd_mux[PCR_BIT_ACQ_RANGE] = stat_in.primary_range_flag;
            end
            PCR_ADDR_SEC_STAT: begin
                rd_mux = PCR_RST_ZERO;
                rd_mux[PCR_BIT_RATE_HI:PCR_BIT_RATE_LO] = stat_in.secondary_rate;
                rd_mux[PCR_BIT_ACQ_HOLD]  = stat_in.secondary_acq_hold_flag;
                rd_mux[PCR_BIT_ACQ_RANGE] = stat_in.secondary_range_flag;
            end
            PCR_ADDR_CAL_B3:      rd_mux = s_q.cal[31:24];
            PCR_ADDR_CAL_B2:      rd_mux = s_q.cal[23:16];
            PCR_ADDR_CAL_B1:      rd_mux = s_q.cal[15:8];
            PCR_ADDR_CAL_B0:      rd_mux = s_q.cal[7:0];
            default:              rd_mux = PCR_RST_ZERO;
        endcase
    end

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.frame_q   = frame_pulse_8k_out;
        s_d.realign_q = eff_realign;
        s_d.ds_q      = ds_n;
        // Pin levels taken on the frame pulse rising edge
        if (frame_pulse_8k_out && !s_q.frame_q) begin
            s_d.pin_mode   = pcr_op_type'({op_select_high, op_select_low});
            s_d.pin_source = source_choice;
        end
        // Register writes, accepted in either control mode
        if (wr_stb) begin
            case (addr)
                PCR_ADDR_MAIN_CTRL:   s_d.main_ctrl = wdata & PCR_MASK_MAIN_CTRL;
                PCR_ADDR_RATE_SEL:    s_d.rate_sel  = wdata & PCR_MASK_RATE_SEL;
                PCR_ADDR_COARSE_HI:   s_d.coarse_hi = wdata & PCR_MASK_COARSE_HI;
                PCR_ADDR_COARSE_LO:   s_d.coarse_lo = wdata & PCR_MASK_FULL;
                PCR_ADDR_T1_OFFSET:   s_d.t1_off    = wdata & PCR_MASK_T1_OFFSET;
                PCR_ADDR_DISABLE_A:   s_d.dis_a     = wdata & PCR_MASK_DISABLE_A;
                PCR_ADDR_DISABLE_B:   s_d.dis_b     = wdata & PCR_MASK_DISABLE_B;
                PCR_ADDR_RECOVERY:    s_d.recovery  = wdata & PCR_MASK_RECOVERY;
                PCR_ADDR_FINE_OFFSET: s_d.fine      = wdata & PCR_MASK_FULL;
                PCR_ADDR_CAL_B3:      s_d.cal[31:24] = wdata;
                PCR_ADDR_CAL_B2:      s_d.cal[23:16] = wdata;
                PCR_ADDR_CAL_B1:      s_d.cal[15:8]  = wdata;
                PCR_ADDR_CAL_B0:      s_d.cal[7:0]   = wdata;
                default: ;
            endcase
        end
        // Read data driven while the strobe is low
        s_d.rdata    = rd_act ? rd_mux : PCR_RST_ZERO;
        s_d.rdata_oe = rd_act;
        // Control handed to the datapath
        s_d.ctrl.op_mode       = eff_mode;
        s_d.ctrl.filter_sel    = sw_mode ? s_q.main_ctrl[PCR_BIT_FILTER]
                                         : loop_filter_select;
        s_d.ctrl.source_sel    = sw_mode ? s_q.main_ctrl[PCR_BIT_SRC]
                                         : s_q.pin_source;
        s_d.ctrl.realign_start = s_q.realign_q & ~eff_realign;
        s_d.ctrl.coarse_en     = s_q.coarse_hi[PCR_BIT_OFF_EN];
        s_d.ctrl.coarse_value  = {s_q.coarse_hi[2:0], s_q.coarse_lo};
        s_d.ctrl.t1_value      = s_q.t1_off[5:3];
        s_d.ctrl.fine_value    = s_q.fine;
        s_d.ctrl.out_disable   = {4'h0, s_q.dis_b[4:0], s_q.dis_a[5:1]};
        s_d.ctrl.auto_hold_rec_dis = s_q.recovery[PCR_BIT_AUTO_HOLD_RECOVERY_DISABLE];
        s_d.ctrl.manual_release    = s_q.recovery[PCR_BIT_MHR];
        s_d.ctrl.osc_cal_value     = s_q.cal;
        s_d.ctrl.rate_sel          = s_q.rate_sel[7:6];
        // Status pins, live in both control modes
        s_d.lock = stat_in.core_locked & ~sel_hold
                   & (s_q.ctrl.op_mode == PCR_OP_NORMAL);
        s_d.hold = sel_hold | (s_q.ctrl.op_mode == PCR_OP_HOLDOVER);
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q              <= '0;
            s_q.main_ctrl    <= PCR_RST_MAIN_CTRL;
            s_q.pin_mode     <= PCR_OP_FREERUN;
            s_q.ctrl.op_mode <= PCR_OP_FREERUN;
            s_q.realign_q    <= 1'b1;
            s_q.ds_q         <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata        = s_q.rdata;
    assign rdata_oe     = s_q.rdata_oe;
    assign ctrl_out     = s_q.ctrl;
    assign lock_out     = s_q.lock;
    assign holdover_out = s_q.hold;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    mode_capture_a: assert property (
        (!sw_mode && frame_pulse_8k_out && !s_q.frame_q
         && {op_select_high, op_select_low} != 2'b11)
        ##1 !sw_mode |=> ctrl_out.op_mode == $past(s_q.pin_mode)
    ) else $error("Pin mode not applied after frame edge");
    reserved_hold_a: assert property (
        (req_mode == PCR_OP_RESERVED) |=> ctrl_out.op_mode == $past(ctrl_out.op_mode)
    ) else $error("Reserved mode changed operating mode");
    sw_ignore_a: assert property (
        (sw_mode && $past(sw_mode))
        |=> ctrl_out.filter_sel == $past(s_q.main_ctrl[PCR_BIT_FILTER])
    ) else $error("Filter pin used under register control");
    hold_pin_a: assert property (
        (s_q.ctrl.op_mode == PCR_OP_HOLDOVER) |=> holdover_out
    ) else $error("Holdover not raised in holdover mode");
    realign_edge_a: assert property (
        $fell(s_q.realign_q) |-> ctrl_out.realign_start ##1 !ctrl_out.realign_start
    ) else $error("Realign start not a single pulse");
    write_back_a: assert property (
        (wr_stb && addr == PCR_ADDR_FINE_OFFSET) ##1 (!wr_stb)[*2] ##0
        (rd_act && addr == PCR_ADDR_FINE_OFFSET) |=> rdata == $past(s_q.fine)
    ) else $error("Read did not return register");
    cal_word_a: assert property (
        (wr_stb && addr == PCR_ADDR_CAL_B3)
        |=> ##1 ctrl_out.osc_cal_value[31:24] == $past(wdata, 2)
    ) else $error("Calibration high byte not applied");
    lock_pin_a: assert property (
        (!stat_in.core_locked) |=> !lock_out
    ) else $error("Lock raised without core lock");

    // Mode and source pins captured only on the frame edge, filter pin followed every cycle
    src_capture_a: assert property (
        (!sw_mode && frame_pulse_8k_out && !s_q.frame_q)
        |=> s_q.pin_source == $past(source_choice)
    ) else $error("Source pin not captured on frame edge");

    pin_mode_keep_a: assert property (
        !(frame_pulse_8k_out && !s_q.frame_q) |=> s_q.pin_mode == $past(s_q.pin_mode)
    ) else $error("Pin mode changed without frame edge");

    filter_pin_a: assert property (
        !sw_mode |=> ctrl_out.filter_sel == $past(loop_filter_select)
    ) else $error("Filter pin not applied under pin control");

    // Register bits in force under register control
    sw_mode_a: assert property (
        (sw_mode && s_q.main_ctrl[PCR_BIT_OP_HI:PCR_BIT_OP_LO] != 2'b11)
        |=> ctrl_out.op_mode == $past(s_q.main_ctrl[PCR_BIT_OP_HI:PCR_BIT_OP_LO])
    ) else $error("Mode bits not applied under register control");

    sw_source_a: assert property (
        sw_mode |=> ctrl_out.source_sel == $past(s_q.main_ctrl[PCR_BIT_SRC])
    ) else $error("Source bit not applied under register control");

    // Status pins and realign pulse
    lock_ok_a: assert property (
        (stat_in.core_locked && !sel_hold && s_q.ctrl.op_mode == PCR_OP_NORMAL)
        |=> lock_out
    ) else $error("Lock not raised while locked");

    acq_hold_a: assert property (
        sel_hold |=> holdover_out
    ) else $error("Holdover not raised on acquisition holdover");

    realign_only_a: assert property (
        ctrl_out.realign_start |-> $fell(s_q.realign_q)
    ) else $error("Realign start without falling edge");

    // Register fields handed to the datapath
    coarse_map_a: assert property (
        {ctrl_out.coarse_en, ctrl_out.coarse_value}
        == $past({s_q.coarse_hi[PCR_BIT_OFF_EN:0], s_q.coarse_lo})
    ) else $error("Coarse offset mapping wrong");

    disable_map_a: assert property (
        ctrl_out.out_disable == {4'h0, $past(s_q.dis_b[4:0]), $past(s_q.dis_a[5:1])}
    ) else $error("Output disable mapping wrong");

    recovery_map_a: assert property (
        {ctrl_out.manual_release, ctrl_out.auto_hold_rec_dis}
        == $past(s_q.recovery[PCR_BIT_MHR:PCR_BIT_AUTO_HOLD_RECOVERY_DISABLE])
    ) else $error("Recovery bits mapping wrong");

    write_mask_a: assert property (
        (wr_stb && addr == PCR_ADDR_MAIN_CTRL)
        |=> (s_q.main_ctrl & ~PCR_MASK_MAIN_CTRL) == PCR_RST_ZERO
    ) else $error("Reserved control bits written");

    cal_low_a: assert property (
        (wr_stb && addr == PCR_ADDR_CAL_B0)
        |=> ##1 ctrl_out.osc_cal_value[7:0] == $past(wdata, 2)
    ) else $error("Calibration low byte not applied");

    // Read port behaviour
    rdata_oe_a: assert property (
        rd_act |=> rdata_oe
    ) else $error("Read data not driven");

    rdata_idle_a: assert property (
        !rd_act |=> !rdata_oe && rdata == PCR_RST_ZERO
    ) else $error("Read data driven without read");

    range_flag_a: assert property (
        (rd_act && addr == PCR_ADDR_CORE_STAT)
        |=> rdata[PCR_BIT_CORE_RANGE_EDGE_FLAG] == $past(stat_in.core_range_edge_flag)
    ) else $error("Range flag not reported");

    acq_status_a: assert property (
        (rd_act && addr == PCR_ADDR_SEC_STAT)
        |=> rdata[PCR_BIT_RATE_HI:PCR_BIT_RATE_LO] == $past(stat_in.secondary_rate)
    ) else $error("Secondary rate not reported");

    acq_flags_a: assert property (
        (rd_act && addr == PCR_ADDR_PRI_STAT)
        |=> rdata[PCR_BIT_ACQ_HOLD:PCR_BIT_ACQ_RANGE]
            == $past({stat_in.primary_acq_hold_flag, stat_in.primary_range_flag})
    ) else $error("Primary flags not reported");

    // Scenario coverage
    write_c: cover property (wr_stb && !sw_mode);
    reserved_c: cover property (req_mode == PCR_OP_RESERVED);
    realign_c: cover property (ctrl_out.realign_start);
    holdover_c: cover property ($rose(holdover_out));
    sw_hold_c: cover property (sw_mode && holdover_out);

endmodule

// [sim/pcr_cpu_model.sv]
`timescale 1ns/1ps
module pcr_cpu_model (
    input  wire logic       clk,
    output logic            cs_n,
    output logic            rd_wr_n,
    output logic            ds_n,
    output logic [6:0]      addr,
    output logic [7:0]      wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       rdata_oe
);
    // Deselected, address and data flipped from their last value
    task automatic idle_bus();
        cs_n = 1'b1;
        ds_n = 1'b1;
        rd_wr_n = 1'b1;
        addr = ~addr;
        wdata = ~wdata;
    endtask

    initial begin
        addr = 7'h00;
        wdata = 8'h00;
        idle_bus();
    end

    // One strobe per access, taken at the next rising edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        cs_n = 1'b0;
        rd_wr_n = 1'b0;
        addr = a;
        wdata = d;
        ds_n = 1'b0;
        @(negedge clk);
        idle_bus();
    endtask

    // Data is valid one edge after the read is seen
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic oe);
        @(negedge clk);
        cs_n = 1'b0;
        rd_wr_n = 1'b1;
        addr = a;
        ds_n = 1'b0;
        repeat (2) @(negedge clk);
        d = rdata;
        oe = rdata_oe;
        idle_bus();
    endtask
endmodule

// [sim/tb_pll_control_register_bank.sv]
`timescale 1ns/1ps
module tb_pll_control_register_bank;
    import pcr_pkg::*;
    localparam logic [7:0] ID = 8'h3c;  // Arbitrary identification value
    localparam logic [6:0] RA [12] = '{7'h04, 7'h06, 7'h07, 7'h11, 7'h13, 7'h14,
                                       7'h19, 7'h1a, 7'h40, 7'h41, 7'h42, 7'h43};
    localparam logic [7:0] RM [12] = '{8'hc0, 8'h0f, 8'hff, 8'h38, 8'h3e, 8'h1f,
                                       8'h06, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         strap = 1'b1;
    logic         ophi = 1'b0;
    logic         oplo = 1'b0;
    logic         filt = 1'b0;
    logic         srcp = 1'b0;
    logic         realign = 1'b1;
    logic         frame = 1'b0;
    logic         cs_n, rd_wr_n, ds_n, oe_w, lock_out, holdover_out;
    logic [6:0]   addr;
    logic [7:0]   wdata, rdata;
    pcr_stat_type stat = '0;
    pcr_ctrl_type ctrl;
    logic [31:0]  seed = 32'h0a110484;
    logic [7:0]   mdl [128];
    int           mismatches = 0;
    int           comparisons = 0;
    int           pulses = 0;
    int           exp_m = 2;
    logic         exp_src = 1'b0;

    initial forever #4 clk = ~clk;

    pcr_bank #(.PART_ID(ID)) dut (.clk(clk), .rstn(rstn), .pin_control_strap(strap),
        .op_select_high(ophi), .op_select_low(oplo), .loop_filter_select(filt),
        .source_choice(srcp), .phase_realign(realign), .frame_pulse_8k_out(frame),
        .cs_n(cs_n), .rd_wr_n(rd_wr_n), .ds_n(ds_n), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rdata_oe(oe_w), .stat_in(stat), .ctrl_out(ctrl),
        .lock_out(lock_out), .holdover_out(holdover_out));
    pcr_cpu_model cpu (.clk(clk), .cs_n(cs_n), .rd_wr_n(rd_wr_n), .ds_n(ds_n),
        .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_oe(oe_w));

    // Count alignment start pulses
    always @(posedge clk) if (ctrl.realign_start === 1'b1) pulses++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       oe;
        cpu.rd(a, d, oe);
        chk("rdata", d, exp);
        chk("rdata_oe", oe, 1'b1);
        @(negedge clk);
        chk("rdata_idle", {oe_w, rdata}, 9'h0);
    endtask

    task automatic pulse_frame();
        @(negedge clk);
        frame = 1'b1;
        repeat (2) @(negedge clk);
        frame = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // Random loop status, then pins and status registers
    task automatic chk_status();
        logic [31:0] r;
        logic        sh, lk, ho;
        r = rnd();
        stat = pcr_stat_type'(r[9:0]);
        sh = exp_src ? stat.secondary_acq_hold_flag : stat.primary_acq_hold_flag;
        lk = stat.core_locked && exp_m == 0 && !sh;
        ho = sh || exp_m == 1;
        repeat (3) @(negedge clk);
        chk("lock_out", lock_out, lk);
        chk("holdover_out", holdover_out, ho);
        rdchk(PCR_ADDR_CORE_STAT, {2'b0, lk, ho, 1'b0, stat.core_range_edge_flag, 2'b0});
        rdchk(PCR_ADDR_PRI_STAT, {3'b0, stat.primary_rate, 1'b0,
              stat.primary_acq_hold_flag, stat.primary_range_flag});
        rdchk(PCR_ADDR_SEC_STAT, {3'b0, stat.secondary_rate, 1'b0,
              stat.secondary_acq_hold_flag, stat.secondary_range_flag});
    endtask

    // Bounded run length
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] v;
        logic [1:0]  c;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        chk("op_mode", ctrl.op_mode, PCR_OP_FREERUN);
        rdchk(PCR_ADDR_MAIN_CTRL, PCR_RST_MAIN_CTRL);
        cpu.wr(PCR_ADDR_PART_ID, ~ID);
        rdchk(PCR_ADDR_PART_ID, ID);
        // Register bank under pin control
        for (int i = 0; i < 12; i++) begin
            v = rnd();
            mdl[RA[i]] = v[7:0] & RM[i];
            cpu.wr(RA[i], v[7:0]);
            rdchk(RA[i], mdl[RA[i]]);
        end
        chk("coarse", {ctrl.coarse_en, ctrl.coarse_value}, {mdl[6][3:0], mdl[7]});
        chk("cal", ctrl.osc_cal_value, {mdl[64], mdl[65], mdl[66], mdl[67]});
        chk("disable", ctrl.out_disable, {4'h0, mdl[20][4:0], mdl[19][5:1]});
        chk("recov", {ctrl.manual_release, ctrl.auto_hold_rec_dis}, mdl[25][2:1]);
        chk("misc", {ctrl.fine_value, ctrl.t1_value, ctrl.rate_sel},
            {mdl[26], mdl[17][5:3], mdl[4][7:6]});
        // Pin control: mode and source wait for the frame pulse
        for (int i = 0; i < 5; i++) begin
            v = rnd();
            c = (i == 4) ? 2'b00 : i[1:0];
            {ophi, oplo, srcp, filt} = {c, v[1:0]};
            repeat (3) @(negedge clk);
            chk("mode_early", ctrl.op_mode, exp_m);
            chk("src_early", ctrl.source_sel, exp_src);
            pulse_frame();
            if (c != 2'b11) exp_m = c;
            exp_src = v[1];
            chk("op_mode", ctrl.op_mode, exp_m);
            chk("source", ctrl.source_sel, exp_src);
            chk("filter", ctrl.filter_sel, v[0]);
            chk_status();
        end
        @(negedge clk);
        realign = 1'b0;
        pulses = 0;
        repeat (6) @(negedge clk);
        chk("pin_realign", pulses, 1);
        // Register control: pins ignored
        strap = 1'b0;
        realign = 1'b1;
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            c = i[1:0];
            {ophi, oplo, srcp, filt} = {~c, ~v[1:0]};
            cpu.wr(PCR_ADDR_MAIN_CTRL, {v[1], 2'b11, c, v[0], 2'b11});
            rdchk(PCR_ADDR_MAIN_CTRL, {v[1], 2'b00, c, v[0], 2'b01});
            pulse_frame();
            exp_m = c;
            exp_src = v[1];
            chk("op_mode", ctrl.op_mode, exp_m);
            chk("source", ctrl.source_sel, exp_src);
            chk("filter", ctrl.filter_sel, v[0]);
            chk_status();
        end
        pulses = 0;
        realign = 1'b0;
        repeat (6) @(negedge clk);
        chk("pin_ignored", pulses, 0);
        cpu.wr(PCR_ADDR_MAIN_CTRL, {v[1], 2'b00, c, v[0], 2'b00});
        repeat (4) @(negedge clk);
        chk("reg_realign", pulses, 1);
        tally_and_finish();
    end
endmodule
